// File: include/tmrset_pkg.sv
// Purpose: Shared constants and types for the timer/counter group.
// Assumes: 32-bit AHB-Lite register access, one register per aligned word.
// Notes: Only the low eight bits of each word are used; the rest read zero.
package tmrset_pkg;
    localparam int ADDR_W = 8;
    // Byte addresses of the registers.
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_RUNFLAG = 8'h04;
    localparam logic [7:0] ADDR_T0_LO = 8'h08;
    localparam logic [7:0] ADDR_T0_HI = 8'h0c;
    localparam logic [7:0] ADDR_T1_LO = 8'h10;
    localparam logic [7:0] ADDR_T1_HI = 8'h14;
    localparam logic [7:0] ADDR_T2_CTRL = 8'h18;
    localparam logic [7:0] ADDR_T2_LO = 8'h1c;
    localparam logic [7:0] ADDR_T2_HI = 8'h20;
    localparam logic [7:0] ADDR_RCAP_LO = 8'h24;
    localparam logic [7:0] ADDR_RCAP_HI = 8'h28;
    localparam logic [7:0] ADDR_BAUD_CTRL = 8'h2c;
    localparam logic [7:0] ADDR_BAUD_FRAC = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h34;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h38;
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_BAUD_FRAC = 8'h00;
    // Bit positions in timer_run_and_flags.
    localparam int RF_T1_OVF = 7;
    localparam int RF_T1_RUN = 6;
    localparam int RF_T0_OVF = 5;
    localparam int RF_T0_RUN = 4;
    localparam int RF_B_PEND = 3;
    localparam int RF_B_TYPE = 2;
    localparam int RF_A_PEND = 1;
    localparam int RF_A_TYPE = 0;
    // Bit positions in baud_timer_control.
    localparam int BT_EN = 7;
    localparam int BT_DIV_W = 3;
    // Synchronised pin indices.
    localparam int PIN_IRQ_A = 0;
    localparam int PIN_IRQ_B = 1;
    localparam int PIN_T0_CNT = 2;
    localparam int PIN_T1_CNT = 3;
    localparam int PIN_T2_CNT = 4;
    localparam int PIN_T2_TRIG = 5;
    localparam int NUM_PINS = 6;
    // Interrupt status bits.
    localparam int IRQ_T0 = 0;
    localparam int IRQ_T1 = 1;
    localparam int IRQ_T2 = 2;
    localparam int IRQ_T2_TRIG = 3;
    localparam int IRQ_A = 4;
    localparam int IRQ_B = 5;
    localparam int IRQ_W = 6;
    // Fractional divider base added to baud_fraction_divider.
    localparam logic [8:0] BAUD_FRAC_BASE = 9'h040;
    localparam logic [7:0] BAUD_STEP = 8'h02;

    typedef enum logic [1:0] {
        TMRSET_M13 = 2'b00,
        TMRSET_M16 = 2'b01,
        TMRSET_M8R = 2'b10,
        TMRSET_MSPLIT = 2'b11
    } tmrset_mode_t;

    typedef struct packed {
        logic gate;
        logic count_sel;
        tmrset_mode_t mode;
    } tmrset_nib_t;

    typedef struct packed {
        logic third_timer_overflow;
        logic third_timer_trigger_flag;
        logic rx_clock_source_sel;
        logic tx_clock_source_sel;
        logic trigger_enable;
        logic third_timer_run_bit;
        logic count_source_sel;
        logic capture_or_reload_sel;
    } tmrset_t2ctl_t;
endpackage

// File: core/tmrset_top.sv
// Purpose: Timer0/1, Timer2 and baud timer group with an AHB-Lite register slave.
// Assumes: One clock hclk (25 MHz); all pins are asynchronous and synchronised here.
// Notes: Internal counting advances once per hclk; pin events are falling edges.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module tmrset_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic irq_a_pin,
    input wire logic irq_b_pin,
    input wire logic t0_count_pin,
    input wire logic t1_count_pin,
    input wire logic t2_count_pin,
    input wire logic capture_trigger_pin,
    output logic t2_count_pin_used,
    output logic t2_trigger_pin_used,
    output logic uart_rx_tick,
    output logic uart_tx_tick,
    output logic irq
);
    logic [7:0] mode_q;
    logic [7:0] runflag_q;
    tmrset_pkg::tmrset_t2ctl_t t2ctl_q;
    logic [7:0] t2_lo_q, t2_hi_q, rcap_lo_q, rcap_hi_q;
    logic [7:0] baud_ctl_q, baud_frac_q;
    logic [tmrset_pkg::IRQ_W-1:0] stat_q, mask_q;
    logic [7:0] tl_q [2];
    logic [7:0] th_q [2];
    logic [tmrset_pkg::NUM_PINS-1:0] s1_q, s2_q, s3_q;
    logic [tmrset_pkg::NUM_PINS-1:0] fall;
    logic wr_q;
    logic [7:0] waddr_q;
    logic [7:0] wdata;
    logic [1:0] ovf;
    logic split_hi_ovf;
    logic t2_step, t2_ovf, t2_trig, t2_baud;
    logic [15:0] t2_cnt, rcap;
    logic baud_tick;
    logic [6:0] pre_q;
    logic [7:0] acc_q;
    logic a_set, b_set;
    logic [tmrset_pkg::IRQ_W-1:0] events;

    // Pin synchronisers; only the second and third stages are read.
    // They reset to the idle-high pin level, so no false level request follows reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end
        else
        begin
            s1_q <= {capture_trigger_pin, t2_count_pin, t1_count_pin, t0_count_pin,
                     irq_b_pin, irq_a_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign fall = s3_q & ~s2_q;

    // AHB-Lite slave: zero wait states, always OKAY, read data registered in the address phase.
    wire addr_ok = hsel && htrans[1] && hready;
    wire [7:0] aaddr = haddr[7:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wdata = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
        end
        else
        begin
            wr_q <= addr_ok && hwrite;
            waddr_q <= aaddr;
        end
    end

    function automatic logic wr_to(input logic [7:0] a);
        wr_to = wr_q && (waddr_q == a);
    endfunction

    logic [7:0] rd_d;
    always_comb
    begin
        rd_d = 8'h00;
        if (aaddr == tmrset_pkg::ADDR_MODE) rd_d = mode_q;
        else if (aaddr == tmrset_pkg::ADDR_RUNFLAG) rd_d = runflag_q;
        else if (aaddr == tmrset_pkg::ADDR_T0_LO) rd_d = tl_q[0];
        else if (aaddr == tmrset_pkg::ADDR_T0_HI) rd_d = th_q[0];
        else if (aaddr == tmrset_pkg::ADDR_T1_LO) rd_d = tl_q[1];
        else if (aaddr == tmrset_pkg::ADDR_T1_HI) rd_d = th_q[1];
        else if (aaddr == tmrset_pkg::ADDR_T2_CTRL) rd_d = t2ctl_q;
        else if (aaddr == tmrset_pkg::ADDR_T2_LO) rd_d = t2_lo_q;
        else if (aaddr == tmrset_pkg::ADDR_T2_HI) rd_d = t2_hi_q;
        else if (aaddr == tmrset_pkg::ADDR_RCAP_LO) rd_d = rcap_lo_q;
        else if (aaddr == tmrset_pkg::ADDR_RCAP_HI) rd_d = rcap_hi_q;
        else if (aaddr == tmrset_pkg::ADDR_BAUD_CTRL) rd_d = baud_ctl_q;
        else if (aaddr == tmrset_pkg::ADDR_BAUD_FRAC) rd_d = baud_frac_q;
        else if (aaddr == tmrset_pkg::ADDR_IRQ_STAT) rd_d = {2'b00, stat_q};
        else if (aaddr == tmrset_pkg::ADDR_IRQ_MASK) rd_d = {2'b00, mask_q};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
            hrdata <= {24'h00_0000, rd_d};
    end

    // Plain configuration registers.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_q <= tmrset_pkg::RST_BYTE;
            baud_ctl_q <= tmrset_pkg::RST_BYTE;
            baud_frac_q <= tmrset_pkg::RST_BAUD_FRAC;
            mask_q <= '0;
        end
        else
        begin
            if (wr_to(tmrset_pkg::ADDR_MODE))
                mode_q <= wdata;
            if (wr_to(tmrset_pkg::ADDR_BAUD_CTRL))
                baud_ctl_q <= wdata;
            if (wr_to(tmrset_pkg::ADDR_BAUD_FRAC))
                baud_frac_q <= wdata;
            if (wr_to(tmrset_pkg::ADDR_IRQ_MASK))
                mask_q <= wdata[tmrset_pkg::IRQ_W-1:0];
        end
    end

    // Timer0 and Timer1.
    tmrset_pkg::tmrset_nib_t nib0;
    assign nib0 = mode_q[3:0];
    wire t0_split = (nib0.mode == tmrset_pkg::TMRSET_MSPLIT);
    wire [1:0] run_bit = {runflag_q[tmrset_pkg::RF_T1_RUN], runflag_q[tmrset_pkg::RF_T0_RUN]};
    assign split_hi_ovf = t0_split && run_bit[1] && (&th_q[0]);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_tmr
            tmrset_pkg::tmrset_nib_t nib;
            logic step, gate_ok;
            logic [7:0] lo_addr, hi_addr;
            assign nib = mode_q[gi*4 +: 4];
            assign gate_ok = !nib.gate || s2_q[tmrset_pkg::PIN_IRQ_A + gi];
            assign step = run_bit[gi] && gate_ok &&
                          (nib.count_sel ? fall[tmrset_pkg::PIN_T0_CNT + gi] : 1'b1);
            assign lo_addr = gi ? tmrset_pkg::ADDR_T1_LO : tmrset_pkg::ADDR_T0_LO;
            assign hi_addr = gi ? tmrset_pkg::ADDR_T1_HI : tmrset_pkg::ADDR_T0_HI;

            always_comb
            begin
                case (nib.mode)
                    tmrset_pkg::TMRSET_M13: ovf[gi] = step && (&{th_q[gi], tl_q[gi][4:0]});
                    tmrset_pkg::TMRSET_M16: ovf[gi] = step && (&{th_q[gi], tl_q[gi]});
                    tmrset_pkg::TMRSET_M8R: ovf[gi] = step && (&tl_q[gi]);
                    default: ovf[gi] = (gi == 0) && step && (&tl_q[gi]);
                endcase
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    tl_q[gi] <= tmrset_pkg::RST_BYTE;
                    th_q[gi] <= tmrset_pkg::RST_BYTE;
                end
                else
                begin
                    if (step)
                    begin
                        case (nib.mode)
                            tmrset_pkg::TMRSET_M13:
                            begin
                                tl_q[gi][4:0] <= tl_q[gi][4:0] + 5'h01;
                                if (&tl_q[gi][4:0])
                                    th_q[gi] <= th_q[gi] + 8'h01;
                            end
                            tmrset_pkg::TMRSET_M16:
                            begin
                                tl_q[gi] <= tl_q[gi] + 8'h01;
                                if (&tl_q[gi])
                                    th_q[gi] <= th_q[gi] + 8'h01;
                            end
                            tmrset_pkg::TMRSET_M8R:
                                tl_q[gi] <= (&tl_q[gi]) ? th_q[gi] : tl_q[gi] + 8'h01;
                            default:
                                if (gi == 0)
                                    tl_q[gi] <= tl_q[gi] + 8'h01;
                        endcase
                    end
                    // In split mode the high half of Timer0 runs on Timer1's run bit.
                    if (gi == 0 && t0_split && run_bit[1])
                        th_q[gi] <= th_q[gi] + 8'h01;
                    if (wr_to(lo_addr))
                        tl_q[gi] <= wdata;
                    if (wr_to(hi_addr))
                        th_q[gi] <= wdata;
                end
            end
        end
    endgenerate

    // External request pending flags; hardware set wins over a software clear.
    wire a_edge = runflag_q[tmrset_pkg::RF_A_TYPE];
    wire b_edge = runflag_q[tmrset_pkg::RF_B_TYPE];
    assign a_set = a_edge ? fall[tmrset_pkg::PIN_IRQ_A] : !s2_q[tmrset_pkg::PIN_IRQ_A];
    assign b_set = b_edge ? fall[tmrset_pkg::PIN_IRQ_B] : !s2_q[tmrset_pkg::PIN_IRQ_B];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            runflag_q <= tmrset_pkg::RST_BYTE;
        else
        begin
            if (wr_to(tmrset_pkg::ADDR_RUNFLAG))
                runflag_q <= wdata;
            // Level mode follows the pin, so a released pin drops the request.
            if (!a_edge && !a_set)
                runflag_q[tmrset_pkg::RF_A_PEND] <= 1'b0;
            if (!b_edge && !b_set)
                runflag_q[tmrset_pkg::RF_B_PEND] <= 1'b0;
            if (a_set)
                runflag_q[tmrset_pkg::RF_A_PEND] <= 1'b1;
            if (b_set)
                runflag_q[tmrset_pkg::RF_B_PEND] <= 1'b1;
            if (ovf[0])
                runflag_q[tmrset_pkg::RF_T0_OVF] <= 1'b1;
            if (ovf[1] || split_hi_ovf)
                runflag_q[tmrset_pkg::RF_T1_OVF] <= 1'b1;
        end
    end

    // Timer2.
    assign t2_cnt = {t2_hi_q, t2_lo_q};
    assign rcap = {rcap_hi_q, rcap_lo_q};
    assign t2_baud = t2ctl_q.rx_clock_source_sel || t2ctl_q.tx_clock_source_sel;
    assign t2_step = t2ctl_q.third_timer_run_bit &&
                     (t2ctl_q.count_source_sel ? fall[tmrset_pkg::PIN_T2_CNT] : 1'b1);
    assign t2_ovf = t2_step && (&t2_cnt);
    assign t2_trig = t2ctl_q.trigger_enable && fall[tmrset_pkg::PIN_T2_TRIG];
    assign t2_count_pin_used = t2ctl_q.count_source_sel;
    assign t2_trigger_pin_used = t2ctl_q.trigger_enable;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            t2ctl_q <= tmrset_pkg::RST_BYTE;
            t2_lo_q <= tmrset_pkg::RST_BYTE;
            t2_hi_q <= tmrset_pkg::RST_BYTE;
            rcap_lo_q <= tmrset_pkg::RST_BYTE;
            rcap_hi_q <= tmrset_pkg::RST_BYTE;
        end
        else
        begin
            // Baud use forces auto-reload, as capture would break the bit clock.
            if (t2_ovf && (t2_baud || !t2ctl_q.capture_or_reload_sel))
                {t2_hi_q, t2_lo_q} <= rcap;
            else if (t2_step)
                {t2_hi_q, t2_lo_q} <= t2_cnt + 16'h0001;
            if (t2_trig && !t2_baud)
            begin
                if (t2ctl_q.capture_or_reload_sel)
                    {rcap_hi_q, rcap_lo_q} <= t2_cnt;
                else
                    {t2_hi_q, t2_lo_q} <= rcap;
            end
            if (wr_to(tmrset_pkg::ADDR_T2_CTRL))
                t2ctl_q <= wdata;
            if (wr_to(tmrset_pkg::ADDR_T2_LO))
                t2_lo_q <= wdata;
            if (wr_to(tmrset_pkg::ADDR_T2_HI))
                t2_hi_q <= wdata;
            if (wr_to(tmrset_pkg::ADDR_RCAP_LO))
                rcap_lo_q <= wdata;
            if (wr_to(tmrset_pkg::ADDR_RCAP_HI))
                rcap_hi_q <= wdata;
            if (t2_ovf && !t2_baud)
                t2ctl_q.third_timer_overflow <= 1'b1;
            if (t2_trig)
                t2ctl_q.third_timer_trigger_flag <= 1'b1;
        end
    end

    // Baud timer: prescale by 2^DIV, then a fractional step of 2 per (64 + frac).
    wire baud_en = baud_ctl_q[tmrset_pkg::BT_EN];
    wire [tmrset_pkg::BT_DIV_W-1:0] div = baud_ctl_q[tmrset_pkg::BT_DIV_W-1:0];
    wire [6:0] pre_mask = 7'(({7'h00, 1'b1} << div) - 8'h01);
    wire pre_tick = baud_en && ((pre_q & pre_mask) == pre_mask);
    wire [8:0] acc_next = {1'b0, acc_q} + {1'b0, tmrset_pkg::BAUD_STEP};
    wire [8:0] frac_lim = {1'b0, baud_frac_q} + tmrset_pkg::BAUD_FRAC_BASE;
    assign baud_tick = pre_tick && (acc_next >= frac_lim);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_q <= 7'h00;
            acc_q <= 8'h00;
        end
        else if (!baud_en)
        begin
            pre_q <= 7'h00;
            acc_q <= 8'h00;
        end
        else
        begin
            pre_q <= pre_q + 7'h01;
            if (pre_tick)
                acc_q <= baud_tick ? 8'(acc_next - frac_lim) : acc_next[7:0];
        end
    end

    // Serial clock selection; an enabled baud timer takes over both directions.
    always_comb
    begin
        if (baud_en)
        begin
            uart_rx_tick = baud_tick;
            uart_tx_tick = baud_tick;
        end
        else
        begin
            uart_rx_tick = t2ctl_q.rx_clock_source_sel ? t2_ovf : ovf[1];
            uart_tx_tick = t2ctl_q.tx_clock_source_sel ? t2_ovf : ovf[1];
        end
    end

    // Sticky interrupt status, write one to clear; a new event wins over the clear.
    assign events = {b_set && b_edge, a_set && a_edge, t2_trig, t2_ovf && !t2_baud,
                     ovf[1] || split_hi_ovf, ovf[0]};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stat_q <= '0;
        else if (wr_to(tmrset_pkg::ADDR_IRQ_STAT))
            stat_q <= (stat_q & ~wdata[tmrset_pkg::IRQ_W-1:0]) | events;
        else
            stat_q <= stat_q | events;
    end
    assign irq = |(stat_q & mask_q);

    wire no_wr = !wr_q;

    AST_T0_STOPS: assert property (@(posedge hclk) disable iff (!hresetn)
        (!run_bit[0] && !t0_split && no_wr) |=> $stable(tl_q[0]))
        else $error("Timer0 moved while stopped.");
    AST_GATE_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
        (nib0.gate && !s2_q[tmrset_pkg::PIN_IRQ_A] && !t0_split && no_wr)
        |=> $stable({th_q[0], tl_q[0]}))
        else $error("Gated Timer0 counted with its pin low.");
    AST_T0_M16_INC: assert property (@(posedge hclk) disable iff (!hresetn)
        (run_bit[0] && !nib0.gate && !nib0.count_sel && nib0.mode == tmrset_pkg::TMRSET_M16
         && no_wr) |=> ({th_q[0], tl_q[0]} == $past({th_q[0], tl_q[0]}) + 16'h0001))
        else $error("Timer0 16-bit count did not advance by one.");
    AST_T0_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        (ovf[0] && nib0.mode == tmrset_pkg::TMRSET_M8R && no_wr)
        |=> tl_q[0] == $past(th_q[0]) && runflag_q[tmrset_pkg::RF_T0_OVF])
        else $error("Timer0 auto-reload or flag missing.");
    AST_EDGE_PEND: assert property (@(posedge hclk) disable iff (!hresetn)
        (a_edge && fall[tmrset_pkg::PIN_IRQ_A]) |=> runflag_q[tmrset_pkg::RF_A_PEND]
        && stat_q[tmrset_pkg::IRQ_A])
        else $error("Edge request did not set pending.");
    AST_RX_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
        (!baud_en && !t2ctl_q.rx_clock_source_sel) |-> (uart_rx_tick == ovf[1]))
        else $error("Receive clock not from Timer1.");
    AST_TX_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
        (!baud_en && t2ctl_q.tx_clock_source_sel) |-> (uart_tx_tick == t2_ovf))
        else $error("Transmit clock not from Timer2.");
    AST_T2_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
        (!t2ctl_q.third_timer_run_bit && !t2_trig && no_wr) |=> $stable(t2_cnt))
        else $error("Timer2 moved while halted.");
    AST_T2_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
        (t2_trig && t2ctl_q.capture_or_reload_sel && !t2_baud && no_wr)
        |=> rcap == $past(t2_cnt) && t2ctl_q.third_timer_trigger_flag)
        else $error("Timer2 capture missed.");
    AST_BAUD_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !baud_en |-> !baud_tick ##1 (pre_q == 7'h00 || baud_en))
        else $error("Baud timer ran while disabled.");
    AST_IRQ_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
        (events[tmrset_pkg::IRQ_T0] && mask_q[tmrset_pkg::IRQ_T0]
         && !wr_to(tmrset_pkg::ADDR_IRQ_MASK)) |=> irq)
        else $error("Masked-in event did not raise the interrupt.");

    COV_T0_OVF: cover property (@(posedge hclk) disable iff (!hresetn) ovf[0]);
    COV_T2_CAP: cover property (@(posedge hclk) disable iff (!hresetn)
        t2_trig && t2ctl_q.capture_or_reload_sel);
    COV_BAUD: cover property (@(posedge hclk) disable iff (!hresetn) baud_tick);
    COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule

// File: tb/tmrset_pin_model.sv
// Purpose: Pin-side partner that drives the count, gate and trigger inputs.
// Assumes: Pins idle high, and an event is a falling edge.
// Notes: The gap argument sets how slowly the edges follow each other.
`timescale 1ns/1ps
module tmrset_pin_model (
    input wire logic hclk,
    output logic [5:0] pins
);
    initial pins = 6'h3f;
    task automatic level(input int idx, input logic v);
        @(posedge hclk);
        pins[idx] <= v;
    endtask
    task automatic pulse(input int idx, input int n, input int gap);
        repeat (n)
        begin
            level(idx, 1'b0);
            repeat (gap) @(posedge hclk);
            level(idx, 1'b1);
            repeat (gap) @(posedge hclk);
        end
    endtask
endmodule

// File: tb/tmrset_bench.sv
// Purpose: Self-checking bench for the timer/counter group.
// Assumes: Zero-wait slave, but every bus wait still polls hreadyout.
// Notes: Pin events need a few edges to pass the synchronisers.
`timescale 1ns/1ps
module tmrset_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, t2_cnt_used, t2_trig_used, rx_tick, tx_tick, irq;
    logic [5:0] pins;
    logic [7:0] rv;
    logic [7:0] hold;
    int error_cnt = 0;
    int checked = 0;
    localparam int FCLK = 25000000;
    localparam int BAUD = 500000;
    // Divide factor is floor(log2(fclk / (32 * baud))), fraction 2 * fclk / (2^DIV * baud) - 64.
    localparam int DIV = $clog2(FCLK / (32 * BAUD) + 1) - 1;
    localparam int FRAC = 2 * FCLK / ((1 << DIV) * BAUD) - 64;
    tmrset_pin_model pm (.hclk(hclk), .pins(pins));
    tmrset_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq_a_pin(pins[0]), .irq_b_pin(pins[1]), .t0_count_pin(pins[2]),
        .t1_count_pin(pins[3]), .t2_count_pin(pins[4]), .capture_trigger_pin(pins[5]),
        .t2_count_pin_used(t2_cnt_used), .t2_trigger_pin_used(t2_trig_used),
        .uart_rx_tick(rx_tick), .uart_tx_tick(tx_tick), .irq(irq));
    initial
    begin
        forever #20 hclk = ~hclk;
    end
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        xfer(a, 1'b0, 8'h00);
        chk8(rv, exp);
    endtask
    task automatic t_timer0;
        wr(tmrset_pkg::ADDR_MODE, 8'h01);
        wr(tmrset_pkg::ADDR_T0_LO, 8'hff);
        wr(tmrset_pkg::ADDR_T0_HI, 8'hff);
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h10);
        repeat (4) @(posedge hclk);
        rchk(tmrset_pkg::ADDR_RUNFLAG, 8'h30);
        rchk(tmrset_pkg::ADDR_IRQ_STAT, 8'h01);
        wr(tmrset_pkg::ADDR_IRQ_MASK, 8'h01);
        @(posedge hclk);
        chk8({7'h0, irq}, 8'h01);
        wr(tmrset_pkg::ADDR_IRQ_STAT, 8'h01);
        @(posedge hclk);
        chk8({7'h0, irq}, 8'h00);
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h00);
        xfer(tmrset_pkg::ADDR_T0_LO, 1'b0, 8'h00);
        hold = rv;
        repeat (5) @(posedge hclk);
        rchk(tmrset_pkg::ADDR_T0_LO, hold);
    endtask
    task automatic t_gate;
        wr(tmrset_pkg::ADDR_MODE, 8'h09);
        wr(tmrset_pkg::ADDR_T0_LO, 8'h00);
        pm.level(0, 1'b0);
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h10);
        repeat (20) @(posedge hclk);
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h00);
        rchk(tmrset_pkg::ADDR_RUNFLAG, 8'h02);
        rchk(tmrset_pkg::ADDR_T0_LO, 8'h00);
        pm.level(0, 1'b1);
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h10);
        repeat (20) @(posedge hclk);
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h00);
        xfer(tmrset_pkg::ADDR_T0_LO, 1'b0, 8'h00);
        // The starting and stopping writes frame 22 counting edges.
        chk8(rv, 8'h16);
    endtask
    task automatic t_edge;
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h01);
        pm.pulse(0, 1, 4);
        rchk(tmrset_pkg::ADDR_RUNFLAG, 8'h03);
        rchk(tmrset_pkg::ADDR_IRQ_STAT, 8'h10);
    endtask
    task automatic t_timer2;
        wr(tmrset_pkg::ADDR_T2_CTRL, 8'h06);
        @(posedge hclk);
        chk8({7'h0, t2_cnt_used}, 8'h01);
        pm.pulse(4, 5, 3);
        rchk(tmrset_pkg::ADDR_T2_LO, 8'h05);
        wr(tmrset_pkg::ADDR_T2_CTRL, 8'h02);
        pm.pulse(4, 2, 3);
        rchk(tmrset_pkg::ADDR_T2_LO, 8'h05);
        wr(tmrset_pkg::ADDR_T2_CTRL, 8'h0d);
        @(posedge hclk);
        chk8({7'h0, t2_trig_used}, 8'h01);
        pm.pulse(5, 1, 4);
        rchk(tmrset_pkg::ADDR_T2_CTRL, 8'h4d);
        xfer(tmrset_pkg::ADDR_RCAP_LO, 1'b0, 8'h00);
        chk8({7'h0, rv > 8'h05}, 8'h01);
    endtask
    // Ticks are counted at falling edges, where the one-cycle pulses are settled.
    task automatic count_ticks(input int n, output int rxn, output int txn);
        rxn = 0;
        txn = 0;
        repeat (n)
        begin
            @(negedge hclk);
            rxn += (rx_tick === 1'b1);
            txn += (tx_tick === 1'b1);
        end
        @(posedge hclk);
    endtask
    task automatic t_ticks;
        int rxn;
        int txn;
        wr(tmrset_pkg::ADDR_T2_CTRL, 8'h00);
        wr(tmrset_pkg::ADDR_MODE, 8'h22);
        wr(tmrset_pkg::ADDR_T0_HI, 8'hfe);
        wr(tmrset_pkg::ADDR_T1_LO, 8'hfe);
        wr(tmrset_pkg::ADDR_T1_HI, 8'hfe);
        wr(tmrset_pkg::ADDR_RUNFLAG, 8'h50);
        wr(tmrset_pkg::ADDR_RCAP_HI, 8'hff);
        wr(tmrset_pkg::ADDR_RCAP_LO, 8'hfc);
        wr(tmrset_pkg::ADDR_T2_HI, 8'hff);
        wr(tmrset_pkg::ADDR_T2_LO, 8'hfc);
        wr(tmrset_pkg::ADDR_T2_CTRL, 8'h24);
        count_ticks(20, rxn, txn);
        chk8(8'(rxn), 8'h05);
        chk8(8'(txn), 8'h0a);
        wr(tmrset_pkg::ADDR_T2_CTRL, 8'h14);
        count_ticks(20, rxn, txn);
        chk8(8'(rxn), 8'h0a);
        chk8(8'(txn), 8'h05);
        wr(tmrset_pkg::ADDR_BAUD_FRAC, 8'(FRAC));
        wr(tmrset_pkg::ADDR_BAUD_CTRL, 8'(8'h80 | DIV));
        count_ticks(200, rxn, txn);
        chk8(8'(rxn), 8'(200 * BAUD / FCLK));
        chk8(8'(txn), 8'(200 * BAUD / FCLK));
        wr(tmrset_pkg::ADDR_BAUD_CTRL, 8'h00);
        count_ticks(20, rxn, txn);
        chk8(8'(rxn), 8'h0a);
    endtask
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(tmrset_pkg::ADDR_MODE, 8'h00);
        rchk(tmrset_pkg::ADDR_BAUD_FRAC, 8'h00);
        rchk(8'h3c, 8'h00);
        chk8({7'h0, hresp}, 8'h00);
        t_timer0();
        t_gate();
        t_edge();
        t_timer2();
        t_ticks();
        report_and_stop();
    end
    initial
    begin
        // Roughly ten times the expected run, so a hung wait cannot stall forever.
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule
